// ---- rtl/cbr_config_regs.sv ----
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - six output edge-rate bits in index 2, one is fast, reset fast
// - index 3 bit 0 sets feedback edge rate, one is fast, reset fast
// - index 3 bit 5 gates software rate change, resets to zero
// - rate code bits 4:3 stored always, act only while gate set
// - index 4 is reserved and always reads all ones
// - index 5 reads fixed revision and vendor nibbles
// - index 6 reads fixed two-bit category and six-bit part identifier
// - index 7 bits 4:0 hold block read length, reset eight
// - block write: address, index, count, data bytes, each acknowledged up to count, data bytes beyond count nacked
// - block read: count first, then successive bytes until host nack
module cbr_config_regs #(
    // arbitrary values
    parameter logic [6:0] P_TARGET_ADDR = 7'h2A,
    parameter logic [3:0] P_REVISION = 4'h3,
    parameter logic [3:0] P_VENDOR = 4'h5,
    parameter logic [1:0] P_DEV_TYPE = 2'h3,
    parameter logic [5:0] P_DEV_ID = 6'h15
) (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda,
    output logic o_sda_oe,
    output logic [5:0] o_edge_speed_out,
    output logic o_edge_speed_feedback,
    output logic o_rate_override,
    output logic [1:0] o_input_rate_code
);
    import cbr_pkg::*;

    function automatic logic [7:0] wmask(input logic [7:0] data, input logic [7:0] mask,
                                         input logic [7:0] ones);
        wmask = (data & mask) | ones;
    endfunction : wmask

    cbr_state_e state_q, state_d;
    logic [3:0] bit_cnt_q, bit_cnt_d;
    logic [7:0] shift_q, shift_d;
    logic [7:0] tx_q, tx_d;
    logic [7:0] index_q, index_d;
    logic [7:0] count_q, count_d;
    logic [1:0] phase_q, phase_d;
    logic oe_q, oe_d;
    logic ack_q, ack_d;
    logic rd_q, rd_d;
    logic [7:0] edge_q;
    logic [7:0] freq_q;
    logic [7:0] blen_q;
    logic rate_override_q;
    logic [1:0] rate_code_q;
    logic scl_p_q, sda_p_q;
    logic [1:0] pins_s;

    cbr_sync u_sync (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .i_async({i_scl, i_sda}),
        .o_sync(pins_s)
    );

    wire scl_s = pins_s[1];
    wire sda_s = pins_s[0];
    wire scl_rise = scl_s & ~scl_p_q;
    wire scl_fall = ~scl_s & scl_p_q;
    wire start_ev = scl_s & scl_p_q & sda_p_q & ~sda_s;
    wire stop_ev = scl_s & scl_p_q & ~sda_p_q & sda_s;
    wire byte_done = (bit_cnt_q == BITS_PER_BYTE);
    wire addr_match = (shift_q[7:1] == P_TARGET_ADDR);
    wire addr_read = shift_q[0];
    wire data_ok = (phase_q != PH_DATA) || (count_q != BYTE_ZERO);
    wire wr_fire = scl_fall && byte_done && (state_q == ST_RXB) && (phase_q == PH_DATA)
                   && (count_q != BYTE_ZERO);
    wire we_edge = wr_fire && (index_q == IDX_EDGE);
    wire we_freq = wr_fire && (index_q == IDX_FREQ);
    wire we_blen = wr_fire && (index_q == IDX_BLEN);

    wire [7:0] rd_rsvd = RSVD_VALUE;
    wire [7:0] rd_revv = {P_REVISION, P_VENDOR};
    wire [7:0] rd_type = {P_DEV_TYPE, P_DEV_ID};
    wire [7:0] rd_byte = (index_q == IDX_EDGE) ? edge_q :
                         (index_q == IDX_FREQ) ? freq_q :
                         (index_q == IDX_RSVD) ? rd_rsvd :
                         (index_q == IDX_REVV) ? rd_revv :
                         (index_q == IDX_TYPE) ? rd_type :
                         (index_q == IDX_BLEN) ? blen_q : UNMAPPED_VALUE;

    always_comb begin
        state_d = state_q;
        bit_cnt_d = bit_cnt_q;
        shift_d = shift_q;
        tx_d = tx_q;
        index_d = index_q;
        count_d = count_q;
        phase_d = phase_q;
        oe_d = oe_q;
        ack_d = ack_q;
        rd_d = rd_q;
        if (stop_ev) begin
            state_d = ST_IDLE;
            oe_d = 1'b0;
        end else if (start_ev) begin
            state_d = ST_ADDR;
            bit_cnt_d = BIT_CNT_ZERO;
            oe_d = 1'b0;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    oe_d = 1'b0;
                end
                ST_ADDR, ST_RXB: begin
                    if (scl_rise) begin
                        shift_d = {shift_q[6:0], sda_s};
                        bit_cnt_d = 4'(bit_cnt_q + BIT_CNT_STEP);
                    end else if (scl_fall && byte_done) begin
                        bit_cnt_d = BIT_CNT_ZERO;
                        state_d = ST_WACK;
                        if (state_q == ST_ADDR) begin
                            ack_d = addr_match;
                            oe_d = addr_match;
                            rd_d = addr_read;
                            tx_d = blen_q;
                            if (addr_match && !addr_read) begin
                                phase_d = PH_INDEX;
                            end
                        end else begin
                            ack_d = data_ok;
                            oe_d = data_ok;
                            rd_d = 1'b0;
                            unique case (phase_q)
                                PH_INDEX: begin
                                    index_d = shift_q;
                                    phase_d = PH_COUNT;
                                end
                                PH_COUNT: begin
                                    count_d = shift_q;
                                    phase_d = PH_DATA;
                                end
                                default: begin
                                    if (data_ok) begin
                                        index_d = 8'(index_q + BYTE_STEP);
                                        count_d = 8'(count_q - BYTE_STEP);
                                    end
                                end
                            endcase
                        end
                    end
                end
                ST_WACK: begin
                    if (scl_fall) begin
                        bit_cnt_d = BIT_CNT_ZERO;
                        if (!ack_q) begin
                            state_d = ST_IDLE;
                            oe_d = 1'b0;
                        end else if (rd_q) begin
                            state_d = ST_TXB;
                            oe_d = ~tx_q[7];
                        end else begin
                            state_d = ST_RXB;
                            oe_d = 1'b0;
                        end
                    end
                end
                ST_TXB: begin
                    if (scl_rise) begin
                        bit_cnt_d = 4'(bit_cnt_q + BIT_CNT_STEP);
                    end else if (scl_fall) begin
                        if (byte_done) begin
                            oe_d = 1'b0;
                            state_d = ST_RACK;
                            bit_cnt_d = BIT_CNT_ZERO;
                        end else begin
                            tx_d = {tx_q[6:0], 1'b0};
                            oe_d = ~tx_q[6];
                        end
                    end
                end
                ST_RACK: begin
                    if (scl_rise) begin
                        if (sda_s) begin
                            state_d = ST_IDLE;
                        end else begin
                            tx_d = rd_byte;
                            index_d = 8'(index_q + BYTE_STEP);
                        end
                    end else if (scl_fall) begin
                        state_d = ST_TXB;
                        oe_d = ~tx_q[7];
                    end
                end
                default: begin
                    state_d = ST_IDLE;
                    oe_d = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            state_q <= ST_IDLE;
            bit_cnt_q <= BIT_CNT_ZERO;
            shift_q <= BYTE_ZERO;
            tx_q <= BYTE_ZERO;
            index_q <= BYTE_ZERO;
            count_q <= BYTE_ZERO;
            phase_q <= PH_INDEX;
            oe_q <= 1'b0;
            ack_q <= 1'b0;
            rd_q <= 1'b0;
            scl_p_q <= BUS_IDLE_LEVEL;
            sda_p_q <= BUS_IDLE_LEVEL;
        end else begin
            state_q <= state_d;
            bit_cnt_q <= bit_cnt_d;
            shift_q <= shift_d;
            tx_q <= tx_d;
            index_q <= index_d;
            count_q <= count_d;
            phase_q <= phase_d;
            oe_q <= oe_d;
            ack_q <= ack_d;
            rd_q <= rd_d;
            scl_p_q <= scl_s;
            sda_p_q <= sda_s;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            edge_q <= EDGE_RESET;
            freq_q <= FREQ_RESET;
            blen_q <= BLEN_RESET;
        end else begin
            if (we_edge) begin
                edge_q <= wmask(shift_q, EDGE_RW_MASK, EDGE_ONES);
            end
            if (we_freq) begin
                freq_q <= wmask(shift_q, FREQ_RW_MASK, FREQ_ONES);
            end
            if (we_blen) begin
                blen_q <= wmask(shift_q, BLEN_RW_MASK, BLEN_ONES);
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            rate_override_q <= 1'b0;
            rate_code_q <= RATE_CODE_OFF;
        end else begin
            rate_override_q <= freq_q[FREQ_GATE_BIT];
            rate_code_q <= freq_q[FREQ_GATE_BIT] ?
                           {freq_q[FREQ_CODE_HI], freq_q[FREQ_CODE_LO]} : RATE_CODE_OFF;
        end
    end

    assign o_edge_speed_out = {edge_q[EDGE_BIT_OUT5], edge_q[EDGE_BIT_OUT4],
                               edge_q[EDGE_BIT_OUT3], edge_q[EDGE_BIT_OUT2],
                               edge_q[EDGE_BIT_OUT1], edge_q[EDGE_BIT_OUT0]};
    assign o_edge_speed_feedback = freq_q[FREQ_FB_BIT];
    assign o_rate_override = rate_override_q;
    assign o_input_rate_code = rate_code_q;
    assign o_sda = SDA_DRIVE_LEVEL;
    assign o_sda_oe = oe_q;
endmodule : cbr_config_regs
`default_nettype wire

// ---- common/cbr_pkg.sv ----
`default_nettype none
package cbr_pkg;
    localparam logic [7:0] IDX_EDGE = 8'h02;
    localparam logic [7:0] IDX_FREQ = 8'h03;
    localparam logic [7:0] IDX_RSVD = 8'h04;
    localparam logic [7:0] IDX_REVV = 8'h05;
    localparam logic [7:0] IDX_TYPE = 8'h06;
    localparam logic [7:0] IDX_BLEN = 8'h07;

    localparam logic [7:0] EDGE_RW_MASK = 8'hDD;
    localparam logic [7:0] EDGE_ONES = 8'h02;
    localparam logic [7:0] EDGE_RESET = 8'hDF;
    localparam logic [7:0] FREQ_RW_MASK = 8'h39;
    localparam logic [7:0] FREQ_ONES = 8'h02;
    localparam logic [7:0] FREQ_RESET = 8'h03;
    localparam logic [7:0] BLEN_RW_MASK = 8'h1F;
    localparam logic [7:0] BLEN_ONES = 8'h00;
    localparam logic [7:0] BLEN_RESET = 8'h08;
    localparam logic [7:0] RSVD_VALUE = 8'hFF;
    localparam logic [7:0] UNMAPPED_VALUE = 8'h00;

    localparam int EDGE_BIT_OUT0 = 0;
    localparam int EDGE_BIT_OUT1 = 2;
    localparam int EDGE_BIT_OUT2 = 3;
    localparam int EDGE_BIT_OUT3 = 4;
    localparam int EDGE_BIT_OUT4 = 6;
    localparam int EDGE_BIT_OUT5 = 7;
    localparam int FREQ_GATE_BIT = 5;
    localparam int FREQ_CODE_HI = 4;
    localparam int FREQ_CODE_LO = 3;
    localparam int FREQ_FB_BIT = 0;

    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] BIT_CNT_ZERO = 4'h0;
    localparam logic [3:0] BIT_CNT_STEP = 4'h1;
    localparam logic [7:0] BYTE_STEP = 8'h01;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [1:0] RATE_CODE_OFF = 2'h0;
    localparam logic SDA_DRIVE_LEVEL = 1'b0;
    localparam logic BUS_IDLE_LEVEL = 1'b1;

    localparam logic [1:0] PH_INDEX = 2'h0;
    localparam logic [1:0] PH_COUNT = 2'h1;
    localparam logic [1:0] PH_DATA = 2'h2;

    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_ADDR = 6'h02,
        ST_WACK = 6'h04,
        ST_RXB = 6'h08,
        ST_TXB = 6'h10,
        ST_RACK = 6'h20
    } cbr_state_e;
endpackage : cbr_pkg
`default_nettype wire

// ---- rtl/cbr_sync.sv ----
`timescale 1ns/100ps
`default_nettype none
module cbr_sync (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic [1:0] i_async,
    output logic [1:0] o_sync
);
    import cbr_pkg::*;

    logic [1:0] meta_q;
    logic [1:0] sync_q;

    // two-flop synchroniser, bus idles high
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            meta_q <= {2{BUS_IDLE_LEVEL}};
            sync_q <= {2{BUS_IDLE_LEVEL}};
        end else begin
            meta_q <= i_async;
            sync_q <= meta_q;
        end
    end

    assign o_sync = sync_q;
endmodule : cbr_sync
`default_nettype wire

// ---- bench/cbr_config_regs_chk.sv ----
`timescale 1ns/100ps
`default_nettype none
module cbr_config_regs_chk (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_scl,
    input wire logic i_sda,
    input wire logic o_sda,
    input wire logic o_sda_oe,
    input wire logic [5:0] o_edge_speed_out,
    input wire logic o_edge_speed_feedback,
    input wire logic o_rate_override,
    input wire logic [1:0] o_input_rate_code
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);
    rst_vals_a: assert property ($rose(i_rst_n) |-> o_edge_speed_out == 6'h3F
        && o_edge_speed_feedback && !o_rate_override && o_input_rate_code == 2'h0)
        else $error("outputs not at reset values");
    code_gate_a: assert property (!o_rate_override |-> o_input_rate_code == 2'h0)
        else $error("rate code active while gate clear");
    sda_low_a: assert property ($rose(o_sda_oe) |-> o_sda == 1'b0 && !i_scl && !$past(i_scl, 3))
        else $error("data pin pulled high or outside clock low");
    edge_hold_a: assert property (!$stable(o_edge_speed_out) |-> !i_scl)
        else $error("edge select changed while clock high");
    fb_hold_a: assert property (!$stable(o_edge_speed_feedback) |-> !i_scl)
        else $error("feedback select changed while clock high");
    gate_hold_a: assert property (!$stable(o_rate_override) |-> !i_scl)
        else $error("gate changed while clock high");
    oe_hold_a: assert property (!$stable(o_sda_oe) |-> !i_scl)
        else $error("data pin changed while clock high");
    ack_len_a: assert property ($rose(o_sda_oe) |=> o_sda_oe [*8])
        else $error("pull-low too short");
endmodule : cbr_config_regs_chk
bind cbr_config_regs cbr_config_regs_chk u_chk (.i_clock(i_clock), .i_rst_n(i_rst_n),
    .i_scl(i_scl), .i_sda(i_sda), .o_sda(o_sda), .o_sda_oe(o_sda_oe),
    .o_edge_speed_out(o_edge_speed_out), .o_edge_speed_feedback(o_edge_speed_feedback),
    .o_rate_override(o_rate_override), .o_input_rate_code(o_input_rate_code));
`default_nettype wire

// ---- bench/cbr_host.sv ----
`timescale 1ns/100ps
`default_nettype none
module cbr_host (
    input wire logic i_clock,
    input wire logic i_sda_bus,
    output logic o_scl,
    output logic o_sda
);
    initial begin
        o_scl = 1'b1;
        o_sda = 1'b1;
    end
    task automatic tick();
        repeat (12) @(posedge i_clock);
    endtask : tick
    task automatic start();
        o_sda <= 1'b1;
        tick();
        o_scl <= 1'b1;
        tick();
        o_sda <= 1'b0;
        tick();
        o_scl <= 1'b0;
        tick();
    endtask : start
    task automatic stop();
        o_sda <= 1'b0;
        tick();
        o_scl <= 1'b1;
        tick();
        o_sda <= 1'b1;
        tick();
    endtask : stop
    task automatic bitx(input logic b, output logic r);
        o_sda <= b;
        tick();
        o_scl <= 1'b1;
        tick();
        r = i_sda_bus;
        o_scl <= 1'b0;
    endtask : bitx
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bitx(d[i], r);
        bitx(1'b1, r);
        ack = !r;
    endtask : wbyte
    task automatic rbyte(input logic nack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
        bitx(nack, r);
    endtask : rbyte
endmodule : cbr_host
`default_nettype wire

// ---- bench/cbr_config_regs_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module cbr_config_regs_tb;
    import cbr_pkg::*;
    // identity values arbitrary
    localparam logic [6:0] ADR = 7'h2A;
    localparam logic [7:0] REVV = 8'h35;
    localparam logic [7:0] TYPI = 8'hD5;
    logic i_clock = 1'b0;
    logic i_rst_n = 1'b0;
    logic scl, hsda, oe, dsda, fb, ovr, a;
    logic [5:0] eo;
    logic [1:0] code;
    logic [7:0] d, seed = 8'h37;
    logic [7:0] mdl [0:7];
    int failures = 0;
    int n_compared = 0;
    wire logic bus = hsda & (oe ? dsda : 1'b1);
    always #50 i_clock = ~i_clock;
    cbr_host host (.i_clock(i_clock), .i_sda_bus(bus), .o_scl(scl), .o_sda(hsda));
    cbr_config_regs #(.P_TARGET_ADDR(ADR), .P_REVISION(REVV[7:4]), .P_VENDOR(REVV[3:0]),
        .P_DEV_TYPE(TYPI[7:6]), .P_DEV_ID(TYPI[5:0])) DUT (.i_clock(i_clock),
        .i_rst_n(i_rst_n), .i_scl(scl), .i_sda(bus), .o_sda(dsda), .o_sda_oe(oe),
        .o_edge_speed_out(eo), .o_edge_speed_feedback(fb), .o_rate_override(ovr),
        .o_input_rate_code(code));
    function automatic logic [7:0] lfsr();
        seed = {seed[6:0], seed[7] ^ seed[5] ^ seed[4] ^ seed[3]};
        return seed;
    endfunction : lfsr
    function automatic logic [7:0] exp_rd(input logic [7:0] i);
        case (i)
            8'h02, 8'h03, 8'h07: return mdl[i[2:0]];
            8'h04: return 8'hFF;
            8'h05: return REVV;
            8'h06: return TYPI;
            default: return 8'h00;
        endcase
    endfunction : exp_rd
    task automatic mreset();
        mdl[2] = 8'hDF;
        mdl[3] = 8'h03;
        mdl[7] = 8'h08;
    endtask : mreset
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
            failures++;
        end
    endtask : cmp
    task automatic chk_out();
        cmp({2'b00, eo}, {2'b00, mdl[2][7:6], mdl[2][4:2], mdl[2][0]});
        cmp({7'h00, fb}, {7'h00, mdl[3][0]});
        cmp({7'h00, ovr}, {7'h00, mdl[3][5]});
        cmp({6'h00, code}, mdl[3][5] ? {6'h00, mdl[3][4:3]} : 8'h00);
    endtask : chk_out
    task automatic blk_wr(input logic [7:0] idx, cnt, nsend, input bit rnd, input logic [7:0] v);
        host.start();
        host.wbyte({ADR, 1'b0}, a);
        cmp({7'h00, a}, 8'h01);
        host.wbyte(idx, a);
        cmp({7'h00, a}, 8'h01);
        host.wbyte(cnt, a);
        cmp({7'h00, a}, 8'h01);
        for (int k = 0; k < nsend; k++) begin
            d = rnd ? lfsr() : v;
            host.wbyte(d, a);
            cmp({7'h00, a}, {7'h00, k < cnt});
            if (k < cnt && (idx + k == 2 || idx + k == 3)) begin
                mdl[idx + k] = (d & (idx + k == 2 ? EDGE_RW_MASK : FREQ_RW_MASK)) | 8'h02;
            end
            if (k < cnt && idx + k == 7) mdl[7] = d & BLEN_RW_MASK;
        end
        host.stop();
        chk_out();
    endtask : blk_wr
    task automatic blk_rd(input logic [7:0] idx, input int n);
        host.start();
        host.wbyte({ADR, 1'b0}, a);
        cmp({7'h00, a}, 8'h01);
        host.wbyte(idx, a);
        cmp({7'h00, a}, 8'h01);
        host.start();
        host.wbyte({ADR, 1'b1}, a);
        cmp({7'h00, a}, 8'h01);
        host.rbyte(1'b0, d);
        cmp(d, mdl[7]);
        for (int k = 0; k < n; k++) begin
            host.rbyte(k == n - 1, d);
            cmp(d, exp_rd(idx + k));
        end
        host.stop();
    endtask : blk_rd
    task automatic give_verdict();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : give_verdict
    initial begin
        repeat (60000) @(posedge i_clock);
        $display("[ERR] %0t timeout", $time);
        failures++;
        give_verdict();
    end
    initial begin
        mreset();
        repeat (16) @(posedge i_clock);
        i_rst_n <= 1'b1;
        chk_out();
        blk_rd(8'h00, 9);
        $display("test reset readback done");
        repeat (3) begin
            blk_wr(8'h02, 8'h06, 8'h06, 1'b1, 8'h00);
            blk_rd(8'h02, 6);
        end
        $display("test random write done");
        for (int k = 0; k < 4; k++) blk_wr(8'h03, 8'h01, 8'h01, 1'b0, 8'h20 | (k << 3));
        blk_wr(8'h03, 8'h01, 8'h01, 1'b0, 8'h18);
        blk_rd(8'h03, 1);
        $display("test rate gate done");
        blk_wr(8'h02, 8'h01, 8'h02, 1'b1, 8'h00);
        blk_rd(8'h02, 2);
        $display("test extra byte done");
        host.start();
        host.wbyte({ADR ^ 7'h01, 1'b0}, a);
        cmp({7'h00, a}, 8'h00);
        host.stop();
        @(posedge i_clock);
        i_rst_n <= 1'b0;
        repeat (3) @(posedge i_clock);
        i_rst_n <= 1'b1;
        mreset();
        @(posedge i_clock);
        chk_out();
        blk_rd(8'h02, 2);
        $display("test address and reset done");
        give_verdict();
    end
endmodule : cbr_config_regs_tb
`default_nettype wire
